// File: hw/wdlsr_pkg.sv
// Constants, field layouts and carrier types for the watchdog lock/status block.
// Assumes an 8-bit register port with one-cycle read latency.
// Functional notes
// - Lock bit freezes all watchdog control fields
// - Lock sets once; only reset clears
// - Status register stays clearable while locked
// - Blocking mode suppresses restarts until flag cleared
// - Reload bit selects defaults reread on restart
// - Config bit switches trigger input pull-down
// - Polarity bit: 0 high, 1 low active
// - Drive bit: 0 push-pull, 1 open-drain
// - Flag clear strobe pulses, reads back zero except when read in the cycle after the write
// - Restart flag sets on restart request
// - Counter clear strobe zeroes pulse counter
// - Pulse counter readable at status bits 1:0
// - Threshold code picks 1,2,4 pulses or off
// - Software reset restores defaults, self-clears
package wdlsr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_CFG1 = 8'h1c;
    localparam logic [7:0] OFS_CFG2 = 8'h1d;
    localparam logic [7:0] OFS_STAT = 8'h1e;
    localparam logic [7:0] OFS_SRST = 8'h1f;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h41;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h01;
    localparam int CFG2_LOCK = 7;
    localparam int CFG2_BLK = 4;
    localparam int CFG2_RLD = 3;
    localparam int CFG2_PD = 2;
    localparam int CFG2_POL = 1;
    localparam int CFG2_OD = 0;
    localparam int STAT_CLRF = 4;
    localparam int STAT_FLAG = 3;
    localparam int STAT_CLRC = 2;
    localparam int SRST_BIT = 0;
    localparam int IRQ_PULSE = 0;
    localparam int IRQ_RESTART = 1;
    localparam logic [1:0] THR_OFF = 2'h0;
    localparam logic [1:0] THR_ONE = 2'h1;
    localparam logic [1:0] THR_TWO = 2'h2;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_TWO = 3'h2;
    localparam logic [2:0] CNT_FOUR = 3'h4;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wdlsr_bus_t;
    typedef struct packed {
        logic restart;
        logic reload;
    } wdlsr_rst_req_t;
endpackage

// File: hw/wdlsr_pulse_cnt.sv
// Watchdog reset-pulse counter with threshold compare.
// Assumes pulse_i is a one-cycle strobe per reset output pulse.
`timescale 1ns/10ps
module wdlsr_pulse_cnt
    import wdlsr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    input wire logic pulse_i,
    input wire logic [1:0] thr_i,
    output logic [1:0] cnt_o,
    output logic hit_o
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic [2:0] lim;
    logic hit;

    always_comb begin
        unique case (thr_i)
            THR_OFF: lim = 3'h0;
            THR_ONE: lim = CNT_ONE;
            THR_TWO: lim = CNT_TWO;
            default: lim = CNT_FOUR;
        endcase
        hit = pulse_i && (thr_i != THR_OFF) && (cnt_ff + 3'h1 >= lim);
        nxt_cnt = cnt_ff;
        if (clr_i || hit) begin
            nxt_cnt = 3'h0;
        // Saturate at 3 so the two-bit status never wraps and a later
        // threshold change cannot miss its compare
        end else if (pulse_i && cnt_ff != 3'h3) begin
            nxt_cnt = cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Counter reports low two bits; value 4 is never held since it saturates at 3
    assign cnt_o = cnt_ff[1:0];
    assign hit_o = hit;
endmodule // wdlsr_pulse_cnt

// File: hw/wdlsr_top.sv
// Watchdog lock, output configuration and status registers.
// Assumes a synchronous register port; pulse_i comes from the window core.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module wdlsr_top
    import wdlsr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic wd_pulse_i,
    input wire logic wd_fault_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic [1:0] window_cfg_o,
    output logic trigger_input_pulldown_o,
    output logic wdr_out_o,
    output logic wdr_oe_o,
    output logic restart_req_o,
    output logic reload_nvm_o,
    output logic irq_o
);
    wdlsr_bus_t bus;
    logic [7:0] cfg1_ff, nxt_cfg1;
    logic [7:0] cfg2_ff, nxt_cfg2;
    logic flag_ff, nxt_flag;
    logic clrf_ff, nxt_clrf;
    logic clrc_ff, nxt_clrc;
    logic srst_ff, nxt_srst;
    logic [1:0] ist_ff, nxt_ist;
    logic [1:0] imsk_ff, nxt_imsk;
    logic [7:0] rdata_ff, nxt_rdata;
    logic wdr_ff, nxt_wdr;
    logic oe_ff, nxt_oe;
    logic pd_ff, rq_ff, rl_ff, irq_ff;
    logic [1:0] win_ff;
    wdlsr_rst_req_t req;
    logic [1:0] cnt;
    logic hit, locked, wr_cfg1, wr_cfg2, wr_stat;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign locked = cfg2_ff[CFG2_LOCK];
    assign wr_cfg1 = bus.wr && bus.addr == OFS_CFG1 && !locked;
    assign wr_cfg2 = bus.wr && bus.addr == OFS_CFG2 && !locked;
    assign wr_stat = bus.wr && bus.addr == OFS_STAT;

    wdlsr_pulse_cnt u_cnt (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .clr_i(clrc_ff || srst_ff),
        .pulse_i(wd_pulse_i),
        .thr_i(cfg1_ff[1:0]),
        .cnt_o(cnt),
        .hit_o(hit)
    );

    always_comb begin
        // Blocking mode holds off restart while flag is up
        req.restart = hit && !(cfg2_ff[CFG2_BLK] && flag_ff);
        req.reload = cfg2_ff[CFG2_RLD];
        nxt_cfg1 = cfg1_ff;
        nxt_cfg2 = cfg2_ff;
        if (wr_cfg1) begin
            nxt_cfg1 = bus.wdata;
        end
        if (wr_cfg2) begin
            // Lock is sticky: a zero write leaves it set
            nxt_cfg2 = bus.wdata & 8'h1f;
            nxt_cfg2[CFG2_LOCK] = bus.wdata[CFG2_LOCK];
        end
        nxt_clrf = wr_stat && bus.wdata[STAT_CLRF];
        nxt_clrc = wr_stat && bus.wdata[STAT_CLRC];
        nxt_srst = bus.wr && bus.addr == OFS_SRST && bus.wdata[SRST_BIT];
        nxt_flag = flag_ff;
        if (clrf_ff) begin
            nxt_flag = 1'b0;
        end
        if (req.restart) begin
            nxt_flag = 1'b1;
        end
        nxt_ist = ist_ff;
        if (bus.wr && bus.addr == OFS_IRQ_STAT) begin
            nxt_ist = ist_ff & ~bus.wdata[1:0];
        end
        nxt_ist[IRQ_PULSE] = nxt_ist[IRQ_PULSE] | wd_pulse_i;
        nxt_ist[IRQ_RESTART] = nxt_ist[IRQ_RESTART] | req.restart;
        nxt_imsk = imsk_ff;
        if (bus.wr && bus.addr == OFS_IRQ_MASK) begin
            nxt_imsk = bus.wdata[1:0];
        end
        nxt_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_CFG1: nxt_rdata = cfg1_ff;
                OFS_CFG2: nxt_rdata = cfg2_ff;
                OFS_STAT: nxt_rdata = {3'h0, clrf_ff, flag_ff, clrc_ff, cnt};
                OFS_SRST: nxt_rdata = {7'h00, srst_ff};
                OFS_IRQ_STAT: nxt_rdata = {6'h00, ist_ff};
                OFS_IRQ_MASK: nxt_rdata = {6'h00, imsk_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
        // Reset output: asserted level set by polarity, OD only sinks
        nxt_wdr = wd_fault_i ^ cfg2_ff[CFG2_POL];
        nxt_oe = cfg2_ff[CFG2_OD] ? !nxt_wdr : 1'b1;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || srst_ff) begin
            cfg1_ff <= CFG1_RST;
            cfg2_ff <= CFG2_RST;
            flag_ff <= 1'b0;
            ist_ff <= 2'h0;
            imsk_ff <= 2'h0;
        end else begin
            cfg1_ff <= nxt_cfg1;
            cfg2_ff <= nxt_cfg2;
            flag_ff <= nxt_flag;
            ist_ff <= nxt_ist;
            imsk_ff <= nxt_imsk;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            clrf_ff <= 1'b0;
            clrc_ff <= 1'b0;
            srst_ff <= 1'b0;
            rdata_ff <= 8'h00;
            wdr_ff <= 1'b0;
            oe_ff <= 1'b1;
            pd_ff <= 1'b0;
            rq_ff <= 1'b0;
            rl_ff <= 1'b0;
            irq_ff <= 1'b0;
            win_ff <= 2'h0;
        end else begin
            clrf_ff <= nxt_clrf;
            clrc_ff <= nxt_clrc;
            srst_ff <= nxt_srst;
            rdata_ff <= nxt_rdata;
            wdr_ff <= nxt_wdr;
            oe_ff <= nxt_oe;
            pd_ff <= cfg2_ff[CFG2_PD];
            rq_ff <= req.restart;
            rl_ff <= req.restart && req.reload;
            irq_ff <= |(ist_ff & imsk_ff);
            win_ff <= cfg1_ff[1:0];
        end
    end

    assign rdata_o = rdata_ff;
    assign window_cfg_o = win_ff;
    assign trigger_input_pulldown_o = pd_ff;
    assign wdr_out_o = wdr_ff;
    assign wdr_oe_o = oe_ff;
    assign restart_req_o = rq_ff;
    assign reload_nvm_o = rl_ff;
    assign irq_o = irq_ff;

    lock_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        locked && !srst_ff |=> locked)
        else $error("lock cleared without reset");
    locked_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        locked && bus.wr && bus.addr == OFS_CFG1 && !srst_ff
        |=> $stable(cfg1_ff))
        else $error("locked config changed");
    flag_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_stat && bus.wdata[STAT_CLRF] && !hit ##1 !req.restart
        |=> !flag_ff)
        else $error("flag not cleared");
    strobe_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clrf_ff |=> !clrf_ff || $past(wr_stat))
        else $error("strobe stuck");
    restart_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        req.restart && !srst_ff |=> flag_ff ##0 rq_ff)
        else $error("restart not flagged");
    block_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg2_ff[CFG2_BLK] && flag_ff |=> !rq_ff)
        else $error("restart not blocked");
    count_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_stat && bus.wdata[STAT_CLRC] ##1 !wd_pulse_i |=> cnt == 2'h0)
        else $error("counter not cleared");
    drive_type_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !cfg2_ff[CFG2_OD] && !srst_ff |=> oe_ff)
        else $error("push-pull not driven");
    polarity_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        1'b1 |=> wdr_ff == ($past(wd_fault_i) ^ $past(cfg2_ff[CFG2_POL])))
        else $error("polarity wrong");
    srst_self_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        srst_ff |=> cfg2_ff == CFG2_RST)
        else $error("soft reset failed");
endmodule // wdlsr_top

// File: bench/wdlsr_core_model.sv
// Window core stand-in: turns bench commands into pulse and fault levels.
// Assumes commands change just after a rising edge of mclk_i.
`timescale 1ns/10ps
module wdlsr_core_model (
    input wire logic mclk_i,
    input wire logic fire_i,
    input wire logic fault_i,
    output logic wd_pulse_o,
    output logic wd_fault_o
);
    logic fire_ff;
    always_ff @(posedge mclk_i) begin
        fire_ff <= fire_i;
    end
    // Edge detect, so a held command never becomes a second pulse
    assign wd_pulse_o = fire_i & ~fire_ff;
    assign wd_fault_o = fault_i;
endmodule // wdlsr_core_model

// File: bench/wdlsr_test.sv
// Self-checking bench for the watchdog lock and status registers.
// Assumes wdlsr_top and the core model; one 100 MHz clock.
`timescale 1ns/10ps
module wdlsr_test
    import wdlsr_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cmd_fire = 1'b0;
    logic cmd_fault = 1'b0;
    logic pulse, fault, pd, wout, woe, rreq, rld, irq;
    logic [1:0] win;
    logic [7:0] rdata_o;
    int n_mismatch = 0;
    int compares = 0;

    always #5 mclk_i = ~mclk_i;

    wdlsr_core_model wdlsr_core_model_inst (.mclk_i(mclk_i),
        .fire_i(cmd_fire), .fault_i(cmd_fault), .wd_pulse_o(pulse),
        .wd_fault_o(fault));
    wdlsr_top wdlsr_top_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .wd_pulse_i(pulse), .wd_fault_i(fault), .rdata_o(rdata_o),
        .window_cfg_o(win), .trigger_input_pulldown_o(pd), .wdr_out_o(wout),
        .wdr_oe_o(woe), .restart_req_o(rreq), .reload_nvm_o(rld),
        .irq_o(irq));

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(nm, e, rdata_o);
    endtask
    // Restart strobes are one cycle wide, so gather them over a span
    task automatic fire(output logic rq, output logic rl);
        rq = 1'b0;
        rl = 1'b0;
        @(posedge mclk_i);
        cmd_fire <= 1'b1;
        @(posedge mclk_i);
        cmd_fire <= 1'b0;
        repeat (5) begin
            #1;
            rq = rq | rreq;
            rl = rl | rld;
            @(posedge mclk_i);
        end
    endtask

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        logic rq, rl;
        logic [7:0] v;
        int n;
        void'($urandom(76));
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1 chk("oe", 8'h01, {7'h0, woe});
        rchk("cfg2", OFS_CFG2, CFG2_RST);
        rchk("stat", OFS_STAT, 8'h00);
        repeat (6) begin
            v = 8'($urandom) & 8'h1f;
            wr(OFS_CFG2, v);
            rchk("cfg2", OFS_CFG2, v);
            chk("pd", {7'h0, v[CFG2_PD]}, {7'h0, pd});
            @(posedge mclk_i);
            cmd_fault <= 1'b1;
            repeat (3) @(posedge mclk_i);
            #1 chk("wdr", {7'h0, ~v[CFG2_POL]}, {7'h0, wout});
            chk("oe", {7'h0, ~v[CFG2_OD] | v[CFG2_POL]}, {7'h0, woe});
            cmd_fault <= 1'b0;
        end
        // Masked event is latched but kept off the line
        wr(OFS_IRQ_MASK, 8'h00);
        wr(OFS_CFG1, 8'h01);
        fire(rq, rl);
        chk("irq", 8'h00, {7'h0, irq});
        rchk("irqst", OFS_IRQ_STAT, 8'h03);
        wr(OFS_IRQ_MASK, 8'h02);
        repeat (2) @(posedge mclk_i);
        #1 chk("irq", 8'h01, {7'h0, irq});
        wr(OFS_IRQ_STAT, 8'h02);
        repeat (2) @(posedge mclk_i);
        #1 chk("irq", 8'h00, {7'h0, irq});
        wr(OFS_CFG2, 8'h08);
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 1 : (1 << (c - 1));
            wr(OFS_CFG1, 8'(c));
            wr(OFS_STAT, 8'h14);
            #1 chk("win", 8'(c), {6'h0, win});
            for (int k = 1; k <= n; k++) begin
                fire(rq, rl);
                chk("rq", {7'h0, c != 0 && k == n}, {7'h0, rq});
                chk("rld", {7'h0, c != 0 && k == n}, {7'h0, rl});
                if (c != 0 && k < n)
                    rchk("cnt", OFS_STAT, 8'(k));
            end
        end
        rchk("flag", OFS_STAT, 8'h08);
        wr(OFS_STAT, 8'h04);
        rchk("stat", OFS_STAT, 8'h08);
        // Blocking mode: second restart held off until flag cleared
        wr(OFS_CFG1, 8'h01);
        wr(OFS_CFG2, 8'h10);
        wr(OFS_STAT, 8'h14);
        fire(rq, rl);
        chk("rq", 8'h01, {7'h0, rq});
        fire(rq, rl);
        chk("rq", 8'h00, {7'h0, rq});
        wr(OFS_STAT, 8'h10);
        rchk("stat", OFS_STAT, 8'h00);
        fire(rq, rl);
        chk("rq", 8'h01, {7'h0, rq});
        wr(OFS_CFG2, 8'h82);
        wr(OFS_CFG2, 8'h01);
        rchk("cfg2", OFS_CFG2, 8'h82);
        wr(OFS_CFG1, 8'h00);
        rchk("cfg1", OFS_CFG1, 8'h01);
        wr(OFS_STAT, 8'h14);
        fire(rq, rl);
        chk("rld", 8'h00, {7'h0, rl});
        wr(OFS_STAT, 8'h10);
        rchk("stat", OFS_STAT, 8'h00);
        rchk("unmap", 8'h55, 8'h00);
        wr(OFS_SRST, 8'h01);
        repeat (3) @(posedge mclk_i);
        rchk("cfg2", OFS_CFG2, CFG2_RST);
        rchk("cfg1", OFS_CFG1, CFG1_RST);
        rchk("srst", OFS_SRST, 8'h00);
        give_verdict();
    end
endmodule // wdlsr_test
